// >>> hw/rtch_defines.svh
// Constants of the reader trigger and command handshake block
`ifndef RTCH_DEFINES_SVH
`define RTCH_DEFINES_SVH

// ============================================================
// Register byte offsets
`define RTCH_OFF_CTRL      12'h000
`define RTCH_OFF_STATUS    12'h004
`define RTCH_OFF_IRQ_STAT  12'h008
`define RTCH_OFF_IRQ_MASK  12'h00C
`define RTCH_OFF_TALLY     12'h010
`define RTCH_OFF_CMD_RES   12'h014
`define RTCH_OFF_CMD_INFO  12'h018
`define RTCH_OFF_CMD_DATA  12'h01C

// ============================================================
// Control fields
`define RTCH_CTRL_STATE_LSB  0
`define RTCH_CTRL_BUSY_BIT   2
`define RTCH_CTRL_PASS_BIT   3
`define RTCH_CTRL_FIN_BIT    4

// Interrupt status bit positions
`define RTCH_IRQ_TRIG      0
`define RTCH_IRQ_CYCLE     1
`define RTCH_IRQ_FINISH    2
`define RTCH_IRQ_CMD       3

// ============================================================
// Reset values and codes
`define RTCH_CTRL_RST      32'h0000_0000
`define RTCH_CMD_OK_CODE   16'h0006
`define RTCH_CMD_BAD_CODE  16'h0015
`define RTCH_BANG_CHAR     8'h21
`define RTCH_CR_CHAR       8'h0D

// Acquisition time per capture
`define RTCH_CAPTURE_NS    5000000
`define RTCH_CLK_NS        20
`define RTCH_CAPTURE_CYC   ((`RTCH_CAPTURE_NS + `RTCH_CLK_NS - 1) / `RTCH_CLK_NS)

`endif

// >>> hw/rtch_pkg.sv
// Types of the reader trigger and command handshake block
package rtch_pkg;

  // Operating state of the reader
  typedef enum logic [1:0] {
    RTCH_MODE_OFF   = 2'h0,
    RTCH_MODE_RUN   = 2'h1,
    RTCH_MODE_SETUP = 2'h2
  } rtch_mode_t;

  // Cyclic words from host to reader
  typedef struct packed {
    logic       trigger;
    logic       commandExecuteRequest;
    logic [7:0] commandByteCount;
  } rtch_host_out_t;

  // Cyclic words from reader to host
  typedef struct packed {
    logic [1:0]  operatingState;
    logic        triggerAccepted;
    logic        acquireIdle;
    logic        acquisitionDone;
    logic [7:0]  cycleTag;
    logic [7:0]  finishedCycleTag;
    logic        cycleSucceeded;
    logic        commandAccepted;
    logic [15:0] commandResultCode;
  } rtch_reader_in_t;

endpackage : rtch_pkg

// >>> hw/rtch_capture_timer.sv
// Acquisition timer: busy for a fixed count after a start pulse
`timescale 1ns/1ps
`default_nettype none
module rtch_capture_timer #(
  parameter int CYCLES = 250000
) (
  input  wire logic clk,      // System clock
  input  wire logic reset_n,  // Async reset, low
  input  wire logic start,    // Start pulse
  output logic      busy      // High while counting
);
  import rtch_pkg::*;

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  // ============================================================
  // Count down
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = 32'(CYCLES);
    end else if (cnt_ff != 32'h0) begin
      nxt_cnt = cnt_ff - 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 32'h0);
endmodule : rtch_capture_timer
`default_nettype wire

// >>> hw/rtch_reader.sv
// Reader side of the trigger and command handshake with APB registers
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtch_defines.svh"
module rtch_reader #(
  parameter int CAPTURE_CYCLES = `RTCH_CAPTURE_CYC,
  parameter int CMD_BYTES      = 16
) (
  input  wire logic            clk,        // 50 MHz clock
  input  wire logic            reset_n,    // Async reset, low
  input  wire logic [11:0]     paddr,      // APB address
  input  wire logic            psel,       // APB select
  input  wire logic            penable,    // APB enable
  input  wire logic            pwrite,     // APB direction
  input  wire logic [31:0]     pwdata,     // APB write data
  output logic [31:0]          prdata,     // APB read data
  output logic                 pready,     // APB ready
  output logic                 pslverr,    // APB error
  input  wire rtch_pkg::rtch_host_out_t hostOut, // Words from host
  input  wire logic [7:0]      cmdByte,    // Command byte written
  input  wire logic [7:0]      cmdByteIdx, // Its index
  input  wire logic            cmdByteWe,  // Byte write strobe
  output rtch_pkg::rtch_reader_in_t readerIn, // Words to host
  output logic                 irq         // Level interrupt
);
  import rtch_pkg::*;

  // ============================================================
  // State
  logic [31:0]     ctrl_ff, nxt_ctrl;
  logic [3:0]      irqStat_ff, nxt_irqStat;
  logic [3:0]      irqMask_ff, nxt_irqMask;
  logic [7:0]      cycleTag_ff, nxt_cycleTag;
  logic [7:0]      finTag_ff, nxt_finTag;
  logic            trigAcc_ff, nxt_trigAcc;
  logic            pass_ff, nxt_pass;
  logic            cmdAcc_ff, nxt_cmdAcc;
  logic [15:0]     cmdCode_ff, nxt_cmdCode;
  logic [15:0]     passCnt_ff, nxt_passCnt;
  logic [15:0]     failCnt_ff, nxt_failCnt;
  logic [7:0]      cmdBuf_ff [CMD_BYTES];
  logic            capBusy, capStart;
  logic            wrEn, rdEn, cmdOk;
  logic [3:0]      events;
  rtch_mode_t      mode;

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign mode = rtch_mode_t'(ctrl_ff[`RTCH_CTRL_STATE_LSB +: 2]);

  // Acquisition timer
  rtch_capture_timer #(
    .CYCLES (CAPTURE_CYCLES)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (capStart),
    .busy    (capBusy)
  );

  // ============================================================
  // Trigger take: host raises trigger while idle and active
  assign capStart = hostOut.trigger & ~trigAcc_ff & ~capBusy &
                    (mode != RTCH_MODE_OFF);

  // Command check: leading bang and CR terminator
  always_comb begin
    cmdOk = (cmdBuf_ff[0] == `RTCH_BANG_CHAR) &&
            (hostOut.commandByteCount != 8'h0) &&
            (hostOut.commandByteCount <= 8'(CMD_BYTES));
    if (cmdOk) begin
      cmdOk = cmdBuf_ff[4'(hostOut.commandByteCount - 8'h1)]
              == `RTCH_CR_CHAR;
    end
  end

  // Next handshake state
  always_comb begin
    nxt_trigAcc = trigAcc_ff;
    nxt_cycleTag = cycleTag_ff;
    nxt_finTag = finTag_ff;
    nxt_pass = pass_ff;
    nxt_cmdAcc = cmdAcc_ff;
    nxt_cmdCode = cmdCode_ff;
    nxt_passCnt = passCnt_ff;
    nxt_failCnt = failCnt_ff;
    events = 4'h0;
    if (capStart) begin
      nxt_trigAcc = 1'b1;
      nxt_cycleTag = cycleTag_ff + 8'h1;
      events[`RTCH_IRQ_TRIG] = 1'b1;
      events[`RTCH_IRQ_CYCLE] = 1'b1;
    end else if (!hostOut.trigger) begin
      nxt_trigAcc = 1'b0;
    end
    // report done when software finishes the cycle
    if (wrEn && paddr == `RTCH_OFF_CTRL && pwdata[`RTCH_CTRL_FIN_BIT]) begin
      nxt_finTag = cycleTag_ff;
      nxt_pass = pwdata[`RTCH_CTRL_PASS_BIT];
      if (pwdata[`RTCH_CTRL_PASS_BIT]) begin
        nxt_passCnt = passCnt_ff + 16'h1;
      end else begin
        nxt_failCnt = failCnt_ff + 16'h1;
      end
      events[`RTCH_IRQ_FINISH] = 1'b1;
    end
    if (hostOut.commandExecuteRequest && !cmdAcc_ff) begin
      nxt_cmdAcc = 1'b1;
      nxt_cmdCode = cmdOk ? `RTCH_CMD_OK_CODE : `RTCH_CMD_BAD_CODE;
      events[`RTCH_IRQ_CMD] = 1'b1;
    end else if (!hostOut.commandExecuteRequest) begin
      nxt_cmdAcc = 1'b0;
    end
  end

  // Next register values; set wins over clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_irqMask = irqMask_ff;
    nxt_irqStat = irqStat_ff;
    if (wrEn && paddr == `RTCH_OFF_CTRL) begin
      nxt_ctrl = pwdata & 32'h0000_000F;
    end
    if (wrEn && paddr == `RTCH_OFF_IRQ_MASK) begin
      nxt_irqMask = pwdata[3:0];
    end
    if (wrEn && paddr == `RTCH_OFF_IRQ_STAT) begin
      nxt_irqStat = irqStat_ff & ~pwdata[3:0];
    end
    nxt_irqStat = nxt_irqStat | events;
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff     <= `RTCH_CTRL_RST;
      irqStat_ff  <= 4'h0;
      irqMask_ff  <= 4'h0;
      cycleTag_ff <= 8'h0;
      finTag_ff   <= 8'h0;
      trigAcc_ff  <= 1'b0;
      pass_ff     <= 1'b0;
      cmdAcc_ff   <= 1'b0;
      cmdCode_ff  <= 16'h0;
      passCnt_ff  <= 16'h0;
      failCnt_ff  <= 16'h0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      irqStat_ff  <= nxt_irqStat;
      irqMask_ff  <= nxt_irqMask;
      cycleTag_ff <= nxt_cycleTag;
      finTag_ff   <= nxt_finTag;
      trigAcc_ff  <= nxt_trigAcc;
      pass_ff     <= nxt_pass;
      cmdAcc_ff   <= nxt_cmdAcc;
      cmdCode_ff  <= nxt_cmdCode;
      passCnt_ff  <= nxt_passCnt;
      failCnt_ff  <= nxt_failCnt;
    end
  end

  // Command byte store, written by the host link
  always_ff @(posedge clk) begin
    if (cmdByteWe && cmdByteIdx < 8'(CMD_BYTES)) begin
      cmdBuf_ff[4'(cmdByteIdx)] <= cmdByte;
    end
  end

  // ============================================================
  // Outputs to host
  always_comb begin
    // state above zero in run or setup
    readerIn.operatingState = ctrl_ff[`RTCH_CTRL_STATE_LSB +: 2];
    readerIn.triggerAccepted = trigAcc_ff;
    readerIn.acquireIdle = ~capBusy;
    readerIn.acquisitionDone = ~capBusy;
    readerIn.cycleTag = cycleTag_ff;
    readerIn.finishedCycleTag = finTag_ff;
    readerIn.cycleSucceeded = pass_ff;
    // only acknowledge and code, no text
    readerIn.commandAccepted = cmdAcc_ff;
    readerIn.commandResultCode = cmdCode_ff;
  end

  assign irq = |(irqStat_ff & irqMask_ff);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // APB read mux
  always_comb begin
    prdata = 32'h0;
    if (rdEn) begin
      unique case (paddr)
        `RTCH_OFF_CTRL:     prdata = {28'h0, ctrl_ff[3:0]};
        `RTCH_OFF_STATUS:   prdata = {16'h0, finTag_ff, cycleTag_ff};
        `RTCH_OFF_IRQ_STAT: prdata = {28'h0, irqStat_ff};
        `RTCH_OFF_IRQ_MASK: prdata = {28'h0, irqMask_ff};
        `RTCH_OFF_TALLY:    prdata = {failCnt_ff, passCnt_ff};
        `RTCH_OFF_CMD_RES:  prdata = {15'h0, cmdAcc_ff, cmdCode_ff};
        `RTCH_OFF_CMD_INFO: prdata = {20'h0, capBusy, pass_ff,
                                      trigAcc_ff, cmdOk,
                                      hostOut.commandByteCount};
        `RTCH_OFF_CMD_DATA: prdata = {24'h0, cmdBuf_ff[0]};
        default:            prdata = 32'h0;
      endcase
    end
  end
endmodule : rtch_reader
`default_nettype wire

// >>> sim/rtch_reader_asserts.sv
// Concurrent checks on the reader handshake ports
`timescale 1ns/1ps
`default_nettype none
`include "rtch_defines.svh"
module rtch_reader_asserts #(
  parameter int CAPTURE_CYCLES = 10
) (
  input wire logic                      clk,      // System clock
  input wire logic                      reset_n,  // Async reset, low
  input wire logic [11:0]               paddr,    // APB address
  input wire logic                      psel,     // APB select
  input wire logic                      penable,  // APB enable
  input wire logic                      pwrite,   // APB direction
  input wire logic [31:0]               pwdata,   // APB write data
  input wire logic                      pready,   // APB ready
  input wire rtch_pkg::rtch_host_out_t  hostOut,  // Host words
  input wire rtch_pkg::rtch_reader_in_t readerIn  // Reader words
);
  import rtch_pkg::*;
  logic take, ctlWr, exe, acc;
  int   lowCnt_ff, nxt_lowCnt;
  // Decoded causes
  assign take = hostOut.trigger && !readerIn.triggerAccepted &&
                readerIn.acquireIdle && readerIn.operatingState != 2'h0;
  assign ctlWr = psel && penable && pready && pwrite &&
                 paddr == `RTCH_OFF_CTRL;
  assign exe = hostOut.commandExecuteRequest;
  assign acc = readerIn.commandAccepted;
  // Length of the busy stretch
  always_comb nxt_lowCnt = readerIn.acquireIdle ? 0 : lowCnt_ff + 1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lowCnt_ff <= 0;
    else lowCnt_ff <= nxt_lowCnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_trig_accept: assert property (
    take |=> readerIn.triggerAccepted) else $error("trigger not taken");
  a_accept_hold: assert property (
    readerIn.triggerAccepted && hostOut.trigger |=> readerIn.triggerAccepted)
    else $error("accept dropped early");
  a_tag_step: assert property (
    take |=> readerIn.cycleTag == $past(readerIn.cycleTag) + 8'h01)
    else $error("cycle tag not advanced");
  a_capture_busy: assert property (
    take |=> !readerIn.acquireIdle && !readerIn.acquisitionDone)
    else $error("idle during capture");
  a_busy_length: assert property (
    $rose(readerIn.acquireIdle) |-> lowCnt_ff >= CAPTURE_CYCLES - 1 &&
    lowCnt_ff <= CAPTURE_CYCLES + 1) else $error("capture length wrong");
  a_state_write: assert property (
    ctlWr |=> readerIn.operatingState == $past(pwdata[1:0]))
    else $error("state not written");
  a_finish_tag: assert property (
    ctlWr && pwdata[4] |=> readerIn.finishedCycleTag ==
    $past(readerIn.cycleTag) && readerIn.cycleSucceeded == $past(pwdata[3]))
    else $error("finish report wrong");
  a_cmd_answer: assert property (
    exe && !acc |=> acc && (readerIn.commandResultCode == 16'h0006 ||
    readerIn.commandResultCode == 16'h0015)) else $error("no command ack");
  a_cmd_release: assert property (
    acc && !exe |=> !acc) else $error("command ack stuck");
endmodule : rtch_reader_asserts
bind rtch_reader rtch_reader_asserts #(.CAPTURE_CYCLES(CAPTURE_CYCLES)) chk (
  .clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .hostOut, .readerIn);
`default_nettype wire

// >>> sim/rtch_host_model.sv
// Host controller model driving the cyclic words
`timescale 1ns/1ps
`default_nettype none
module rtch_host_model (
  input  wire logic                      clk,        // System clock
  input  wire logic                      reset_n,    // Async reset, low
  input  wire rtch_pkg::rtch_reader_in_t readerIn,   // Reader words
  output rtch_pkg::rtch_host_out_t       hostOut,    // Host words
  output logic [7:0]                     cmdByte,    // Command byte
  output logic [7:0]                     cmdByteIdx, // Byte index
  output logic                           cmdByteWe   // Byte strobe
);
  import rtch_pkg::*;
  logic       trig, exe, req, reqOld, pend, captured;
  logic [7:0] cnt, savedCyc, savedFin, report;
  logic [15:0] lastCode;
  int         passTally, failTally;
  assign hostOut = '{trig, exe, cnt};
  initial begin
    req = 1'h0; exe = 1'h0; cnt = 8'h00;
    cmdByte = 8'h00; cmdByteIdx = 8'h00; cmdByteWe = 1'h0;
  end
  // Trigger, tag tracking and report tallies
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig <= 1'h0; pend <= 1'h0; reqOld <= 1'h0; captured <= 1'h0;
      savedCyc <= 8'h00; savedFin <= 8'h00; passTally <= 0; failTally <= 0;
      report <= 8'h00;
    end else begin
      reqOld <= req;
      if (req && !reqOld && !pend && !readerIn.triggerAccepted &&
          readerIn.acquireIdle && readerIn.operatingState != 2'h0) begin
        trig <= 1'h1;
        pend <= 1'h1;
      end
      if (trig && readerIn.triggerAccepted) trig <= 1'h0;
      if (pend && readerIn.cycleTag != savedCyc) begin
        savedCyc <= readerIn.cycleTag;
        pend <= 1'h0;
      end
      captured <= readerIn.finishedCycleTag != savedFin;
      savedFin <= readerIn.finishedCycleTag;
      if (captured) report <= readerIn.finishedCycleTag;
      if (captured && readerIn.cycleSucceeded) passTally <= passTally + 1;
      if (captured && !readerIn.cycleSucceeded) failTally <= failTally + 1;
    end
  end
  // Pulse the user trigger request
  task automatic pull();
    @(posedge clk);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
  endtask : pull
  // load bytes with CR, execute, release
  task automatic send(input string s);
    int n;
    @(posedge clk);
    for (n = 0; n <= s.len(); n++) begin
      cmdByte <= (n < s.len()) ? s[n] : 8'h0D;
      cmdByteIdx <= n[7:0];
      cmdByteWe <= 1'h1;
      @(posedge clk);
    end
    cmdByteWe <= 1'h0;
    cnt <= 8'(s.len() + 1);
    exe <= 1'h1;
    // Hold execute until accept is seen at a rising edge
    do begin
      @(posedge clk);
    end while (readerIn.commandAccepted !== 1'h1);
    lastCode = readerIn.commandResultCode;
    exe <= 1'h0;
    do begin
      @(posedge clk);
    end while (readerIn.commandAccepted !== 1'h0);
  endtask : send
endmodule : rtch_host_model
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench for the reader handshake block
`timescale 1ns/1ps
`default_nettype none
`include "rtch_defines.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import rtch_pkg::*;
  logic            clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [7:0]      cmdByte, cmdByteIdx;
  logic            cmdByteWe, err;
  rtch_host_out_t  hostOut;
  rtch_reader_in_t readerIn;
  int              errors = 0, checks = 0, cyc = 0, i;
  rtch_reader #(.CAPTURE_CYCLES(10)) uut (.clk, .reset_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .hostOut,
    .cmdByte, .cmdByteIdx, .cmdByteWe, .readerIn, .irq);
  rtch_host_model host (.clk, .reset_n, .readerIn, .hostOut, .cmdByte,
    .cmdByteIdx, .cmdByteWe);
  // Clock and hang limit
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin errors++; complete_run(); end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // One APB transfer, read data into rd
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    logic ok;
    @(posedge clk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'h1; penable <= 1'h0;
    @(posedge clk);
    penable <= 1'h1;
    // Wait for ready at a rising edge; data taken at that edge
    do begin
      @(posedge clk);
      ok = pready;
      rd = prdata;
      err = pslverr;
    end while (ok !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk);
  endtask : apb
  // Wait until reader and host are quiet
  task automatic settle();
    int n;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (readerIn.acquireIdle && !host.pend && !host.trig && !host.captured
          && host.savedFin == readerIn.finishedCycleTag) break;
    end
  endtask : settle
  initial begin
    reset_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    `CHK("idle", 1'h1, readerIn.acquireIdle)
    apb(`RTCH_OFF_CTRL, 1'h0, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    // Run then setup state, pass then fail
    for (i = 0; i < 2; i++) begin
      apb(`RTCH_OFF_CTRL, 1'h1, 32'(i + 1));
      `CHK("state", 2'(i + 1), readerIn.operatingState)
      host.pull();
      settle();
      `CHK("tag", 8'(i + 1), host.savedCyc)
      apb(`RTCH_OFF_CTRL, 1'h1, 32'h10 | 32'((1 - i) << 3) | 32'(i + 1));
      settle();
      `CHK("fin", 8'(i + 1), readerIn.finishedCycleTag)
      `CHK("report", 8'(i + 1), host.report)
      `CHK("ok", 1'(1 - i), readerIn.cycleSucceeded)
      `CHK("pass", 1, host.passTally)
    end
    `CHK("fail", 1, host.failTally)
    apb(`RTCH_OFF_STATUS, 1'h0, 32'h0);
    `CHK("status", 32'h0202, rd)
    apb(`RTCH_OFF_TALLY, 1'h0, 32'h0);
    `CHK("tally", 32'h0001_0001, rd)
    // Raise, mask and clear the interrupt
    apb(`RTCH_OFF_IRQ_STAT, 1'h0, 32'h0);
    `CHK("irq stat", 32'h7, rd)
    `CHK("irq masked", 1'h0, irq)
    apb(`RTCH_OFF_IRQ_MASK, 1'h1, 32'h4);
    `CHK("irq on", 1'h1, irq)
    apb(`RTCH_OFF_IRQ_STAT, 1'h1, 32'h4);
    `CHK("irq clear", 1'h0, irq)
    // Good and bad commands
    host.send("!TRIGGER");
    `CHK("cmd ok", 16'h0006, host.lastCode)
    host.send("TRIGGER");
    `CHK("cmd bad", `RTCH_CMD_BAD_CODE, host.lastCode)
    apb(`RTCH_OFF_CMD_RES, 1'h0, 32'h0);
    `CHK("cmd res", 32'(`RTCH_CMD_BAD_CODE), rd)
    apb(`RTCH_OFF_CMD_INFO, 1'h0, 32'h0);
    `CHK("cmd info", 32'h0000_0008, rd)
    apb(`RTCH_OFF_CMD_DATA, 1'h0, 32'h0);
    `CHK("cmd data", 32'h0000_0054, rd)
    // Stopped reader gets no trigger
    apb(`RTCH_OFF_CTRL, 1'h1, 32'h0);
    host.pull();
    settle();
    `CHK("off", 8'h02, readerIn.cycleTag)
    // Unmapped place reads zero
    apb(12'h040, 1'h1, 32'hFFFF_FFFF);
    apb(12'h040, 1'h0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'h0, err)
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
